// ### hdl/mjirc_buf.sv
// two-entry buffer with valid and ready on both sides
module mjirc_buf (
   input wire logic clk,
   input wire logic rst,
   input wire mjirc_pkg::mjirc_sym_s inData,
   input wire logic inValid,
   output logic inReady,
   output mjirc_pkg::mjirc_sym_s outData,
   output logic outValid,
   input wire logic outReady
);
   mjirc_pkg::mjirc_sym_s mem_r [mjirc_pkg::BUF_DEPTH];
   mjirc_pkg::mjirc_sym_s mem_nxt [mjirc_pkg::BUF_DEPTH];
   logic wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic push, pop;

   // pointer and count update
   always_comb begin
      push = inValid && (cnt_r != 2'(mjirc_pkg::BUF_DEPTH));
      pop = outReady && (cnt_r != 2'h0);
      for (int i = 0; i < mjirc_pkg::BUF_DEPTH; i++) begin
         mem_nxt[i] = mem_r[i];
      end
      if (push) begin
         mem_nxt[wrPtr_r] = inData;
      end
      wrPtr_nxt = push ? ~wrPtr_r : wrPtr_r;
      rdPtr_nxt = pop ? ~rdPtr_r : rdPtr_r;
      cnt_nxt = cnt_r + 2'(push) - 2'(pop);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_r <= 1'b0;
         rdPtr_r <= 1'b0;
         cnt_r <= 2'h0;
         for (int i = 0; i < mjirc_pkg::BUF_DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         wrPtr_r <= wrPtr_nxt;
         rdPtr_r <= rdPtr_nxt;
         cnt_r <= cnt_nxt;
         mem_r <= mem_nxt;
      end
   end

   assign inReady = cnt_r != 2'(mjirc_pkg::BUF_DEPTH);
   assign outValid = cnt_r != 2'h0;
   assign outData = mem_r[rdPtr_r];
endmodule : mjirc_buf

// ### hdl/mjirc_top.sv
// jabber supervision of transmit and Manchester receive checking
module mjirc_top #(
   parameter int unsigned WINDOW_CYC = mjirc_pkg::WINDOW_CYC,
   parameter int unsigned HOLDOFF_CYC = mjirc_pkg::HOLDOFF_CYC,
   parameter int unsigned TXIDLE_CYC = mjirc_pkg::TXIDLE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic txEnIn,
   input wire logic txDataIn,
   output logic txEnLine,
   output logic txDataLine,
   input wire logic rxLine,
   output logic rxEcho,
   output logic jabber,
   output logic symData,
   output logic symErr,
   output logic symValid,
   input wire logic symReady,
   output logic overrun
);
   // ---------------- jabber supervision ----------------
   mjirc_pkg::mjirc_jab_e jab_r, jab_nxt;
   logic [27:0] jabCnt_r, jabCnt_nxt;
   logic [15:0] idleCnt_r, idleCnt_nxt;
   logic txEn_r, txEn_nxt, txD_r, txD_nxt;
   logic jabber_r, jabber_nxt;

   // jabber state and timers, driven only by own transmit activity
   always_comb begin
      jab_nxt = jab_r;
      jabCnt_nxt = jabCnt_r;
      idleCnt_nxt = idleCnt_r;
      case (jab_r)
         mjirc_pkg::JB_IDLE: begin
            jabCnt_nxt = '0;
            if (txEnIn) begin
               jab_nxt = mjirc_pkg::JB_ACTIVE; // restart window per frame
               idleCnt_nxt = '0;
            end
         end
         mjirc_pkg::JB_ACTIVE: begin
            jabCnt_nxt = jabCnt_r + 28'h000_0001; // counts local clocks
            if (txEnIn) begin
               idleCnt_nxt = '0;
            end else begin
               idleCnt_nxt = idleCnt_r + 16'h0001;
            end
            if (!txEnIn && (32'(idleCnt_r) + 32'h0000_0001 >= TXIDLE_CYC)) begin
               jab_nxt = mjirc_pkg::JB_IDLE; // frame ended inside window
            end else if (32'(jabCnt_r) + 32'h0000_0001 >= WINDOW_CYC) begin
               jab_nxt = mjirc_pkg::JB_INHIBIT; // too long: inhibit
               jabCnt_nxt = '0;
            end
         end
         mjirc_pkg::JB_INHIBIT: begin
            jabCnt_nxt = jabCnt_r + 28'h000_0001;
            if (32'(jabCnt_r) + 32'h0000_0001 >= HOLDOFF_CYC) begin
               jab_nxt = mjirc_pkg::JB_IDLE; // self re-arm after hold-off
               jabCnt_nxt = '0;
            end
         end
         default: begin
            jab_nxt = mjirc_pkg::JB_IDLE;
            jabCnt_nxt = '0;
         end
      endcase
      txEn_nxt = txEnIn && (jab_nxt != mjirc_pkg::JB_INHIBIT); // block output
      txD_nxt = txDataIn && txEn_nxt;
      jabber_nxt = (jab_nxt == mjirc_pkg::JB_INHIBIT); // inhibit flag as a flop
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         jab_r <= mjirc_pkg::JB_IDLE;
         jabCnt_r <= '0;
         idleCnt_r <= '0;
         txEn_r <= 1'b0;
         txD_r <= 1'b0;
         jabber_r <= 1'b0;
      end else begin
         jab_r <= jab_nxt;
         jabCnt_r <= jabCnt_nxt;
         idleCnt_r <= idleCnt_nxt;
         txEn_r <= txEn_nxt;
         txD_r <= txD_nxt;
         jabber_r <= jabber_nxt;
      end
   end

   // ---------------- receive echo and decode ----------------
   logic rxPrev_r, rxPrev_nxt;
   logic echo_r, echo_nxt;
   logic [15:0] ivl_r, ivl_nxt;
   logic inFrame_r, inFrame_nxt;
   logic midPend_r, midPend_nxt; // a half-bit edge seen, awaiting mid-bit
   logic ovr_r, ovr_nxt;
   logic edgeSeen;
   mjirc_pkg::mjirc_sym_s sym;
   logic symPush;
   logic bufInReady;

   // edge interval measure and Manchester symbol decision
   always_comb begin
      edgeSeen = rxLine != rxPrev_r;
      rxPrev_nxt = rxLine;
      echo_nxt = (jab_nxt == mjirc_pkg::JB_INHIBIT) ? 1'b0 : rxLine; // stop echo
      ivl_nxt = (ivl_r == 16'hffff) ? ivl_r : ivl_r + 16'h0001;
      inFrame_nxt = inFrame_r;
      midPend_nxt = midPend_r;
      sym = '0;
      symPush = 1'b0;
      if (ivl_r > mjirc_pkg::GAP_CYC) begin
         inFrame_nxt = 1'b0; // quiet line ends the frame
         midPend_nxt = 1'b0;
      end
      if (edgeSeen) begin
         ivl_nxt = 16'h0001; // edge cycle counts, so bands match true spacing
         if (!inFrame_r) begin
            inFrame_nxt = 1'b1; // first edge taken as mid-bit
            midPend_nxt = 1'b0;
            sym.data = rxLine;
            symPush = 1'b1;
         end else if (ivl_r >= mjirc_pkg::HALF_MIN && ivl_r <= mjirc_pkg::HALF_MAX) begin
            // half-bit spacing with jitter margin
            if (midPend_r) begin
               midPend_nxt = 1'b0;
               sym.data = rxLine; // mid-bit edge direction gives the bit
               symPush = 1'b1;
            end else begin
               midPend_nxt = 1'b1; // boundary edge
            end
         end else if (ivl_r >= mjirc_pkg::FULL_MIN && ivl_r <= mjirc_pkg::FULL_MAX
                      && !midPend_r) begin
            sym.data = rxLine; // full-bit spacing, mid to mid
            symPush = 1'b1;
         end else begin
            sym.err = 1'b1; // spacing outside decodable bands
            sym.data = rxLine;
            symPush = 1'b1;
            midPend_nxt = 1'b0;
         end
      end
      ovr_nxt = symPush && !bufInReady; // word lost only if buffer full
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rxPrev_r <= rxLine; // track line level, no false edge after reset
         echo_r <= 1'b0;
         ivl_r <= 16'hffff;
         inFrame_r <= 1'b0;
         midPend_r <= 1'b0;
         ovr_r <= 1'b0;
      end else begin
         rxPrev_r <= rxPrev_nxt;
         echo_r <= echo_nxt;
         ivl_r <= ivl_nxt;
         inFrame_r <= inFrame_nxt;
         midPend_r <= midPend_nxt;
         ovr_r <= ovr_nxt;
      end
   end

   mjirc_pkg::mjirc_sym_s bufOut;

   // decoded symbols toward the sublayer
   mjirc_buf u_buf (
      .clk(clk),
      .rst(rst),
      .inData(sym),
      .inValid(symPush),
      .inReady(bufInReady),
      .outData(bufOut),
      .outValid(symValid),
      .outReady(symReady)
   );

   assign txEnLine = txEn_r;
   assign txDataLine = txD_r;
   assign rxEcho = echo_r;
   assign jabber = jabber_r;
   assign symData = bufOut.data;
   assign symErr = bufOut.err;
   assign overrun = ovr_r;
endmodule : mjirc_top

// ### inc/mjirc_pkg.sv
// package: constants, types and timing counts for the jabber inhibit and receive check block
// Operation
// - jabber window fixed between 5 and 15 ms; normal frame passes inside it
// - transmission longer than window blocks all further transmit output
// - on jabber, stop echoing receive signal line toward the sublayer
// - hold-off of 500 ms, plus or minus half, then re-enable transmit
// - jabber detection autonomous, from own transmit activity only
// - receive path decodes Manchester streams at 1 Mbit/s
// - decode correctly with adjacent crossing spacing off by up to 0.10 bit
// - nominal transition spacing is half a bit or one full bit
// - flag error when transition jitter exceeds what decoder can handle
// - recover by itself within 3 seconds after a disturbance ends
package mjirc_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned CLK_NS = 5;
   // jabber window, chosen inside the allowed span
   localparam int unsigned WINDOW_MS = 10;
   localparam int unsigned WINDOW_CYC = WINDOW_MS * (CLK_HZ / 1000);
   localparam int unsigned HOLDOFF_MS = 500;
   localparam int unsigned HOLDOFF_CYC = HOLDOFF_MS * (CLK_HZ / 1000);
   // transmit idle needed before the window restarts: 4 bit times
   localparam int unsigned TXIDLE_NS = 4000;
   localparam int unsigned TXIDLE_CYC = (TXIDLE_NS + CLK_NS - 1) / CLK_NS;
   // bit timing: BIT_NS in ns, the rest in clock cycles
   localparam int unsigned BIT_NS = 1000;
   localparam int unsigned BIT_CYC = BIT_NS / CLK_NS;
   localparam int unsigned HALF_CYC = BIT_CYC / 2;
   localparam int unsigned JIT_CYC = BIT_CYC / 10;
   // accepted interval bands: half bit and full bit, each +-0.10 bit
   localparam logic [15:0] HALF_MIN = 16'(HALF_CYC - JIT_CYC);
   localparam logic [15:0] HALF_MAX = 16'(HALF_CYC + JIT_CYC);
   localparam logic [15:0] FULL_MIN = 16'(BIT_CYC - JIT_CYC);
   localparam logic [15:0] FULL_MAX = 16'(BIT_CYC + JIT_CYC);
   // a gap above this ends the frame
   localparam logic [15:0] GAP_CYC = 16'(2 * BIT_CYC);
   localparam int unsigned BUF_DEPTH = 2;

   typedef struct packed {
      logic data;
      logic err;
   } mjirc_sym_s;

   typedef enum logic [1:0] {JB_IDLE, JB_ACTIVE, JB_INHIBIT} mjirc_jab_e;
endpackage : mjirc_pkg

// ### sim/mjirc_mds_model.sv
// sublayer model: sends frames, consumes symbols, stalls on request
module mjirc_mds_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire logic [15:0] len,
   input wire logic stall,
   output logic txEnIn,
   output logic txDataIn,
   output logic symReady
);
   logic [15:0] left_r;
   // frame length counter; data changes every cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         left_r <= 16'h0000;
         txDataIn <= 1'h0;
      end else begin
         left_r <= go ? len : (left_r != 16'h0000) ? left_r - 16'h0001 : left_r;
         txDataIn <= ~txDataIn;
      end
   end
   assign txEnIn = (left_r != 16'h0000);
   assign symReady = !stall; // slow consumer when stalled
endmodule : mjirc_mds_model

// ### sim/mjirc_monitor.sv
// checker: port relations of jabber supervision and symbol path
module mjirc_monitor #(
   parameter int unsigned WINDOW_CYC = mjirc_pkg::WINDOW_CYC,
   parameter int unsigned HOLDOFF_CYC = mjirc_pkg::HOLDOFF_CYC,
   parameter int unsigned TXIDLE_CYC = mjirc_pkg::TXIDLE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic txEnIn,
   input wire logic txDataIn,
   input wire logic txEnLine,
   input wire logic txDataLine,
   input wire logic rxLine,
   input wire logic rxEcho,
   input wire logic jabber,
   input wire logic symData,
   input wire logic symErr,
   input wire logic symValid,
   input wire logic symReady,
   input wire logic overrun
);
   int unsigned jabCnt_r;
   int unsigned txCnt_r;
   // run lengths of inhibit and of line drive
   always_ff @(posedge clk) begin
      jabCnt_r <= (rst || !jabber) ? 0 : jabCnt_r + 1;
      txCnt_r <= (rst || !txEnLine) ? 0 : txCnt_r + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_block; jabber |-> !txEnLine; endproperty
   a_block: assert property (p_block) else $error("drive in inhibit");
   property p_data; txEnLine |-> txDataLine == $past(txDataIn); endproperty
   a_data: assert property (p_data) else $error("data path");
   property p_mute; jabber |-> !rxEcho; endproperty
   a_mute: assert property (p_mute) else $error("echo in inhibit");
   property p_echo;
      !jabber && !$past(jabber) && !$past(rst) |-> rxEcho == $past(rxLine);
   endproperty
   a_echo: assert property (p_echo) else $error("echo path");
   property p_follow;
      !jabber && !$past(jabber) && !$past(rst) |-> txEnLine == $past(txEnIn);
   endproperty
   a_follow: assert property (p_follow) else $error("enable path");
   property p_cause; $rose(jabber) |-> $past(txEnIn) && $past(txEnLine); endproperty
   a_cause: assert property (p_cause) else $error("jabber without tx");
   property p_window; txCnt_r <= WINDOW_CYC; endproperty
   a_window: assert property (p_window) else $error("window overrun");
   property p_hold;
      $fell(jabber) |-> jabCnt_r >= HOLDOFF_CYC - 1 && jabCnt_r <= HOLDOFF_CYC + 1;
   endproperty
   a_hold: assert property (p_hold) else $error("hold-off length");
   property p_recover; jabCnt_r <= HOLDOFF_CYC + 1; endproperty
   a_recover: assert property (p_recover) else $error("no recovery");
   property p_stand; symValid && !symReady |=> symValid && $stable(symData) && $stable(symErr); endproperty
   a_stand: assert property (p_stand) else $error("symbol lost");
endmodule : mjirc_monitor
bind mjirc_top mjirc_monitor #(.WINDOW_CYC(WINDOW_CYC), .HOLDOFF_CYC(HOLDOFF_CYC),
   .TXIDLE_CYC(TXIDLE_CYC)) mon_u (.clk(clk), .rst(rst), .txEnIn(txEnIn), .txDataIn(txDataIn),
   .txEnLine(txEnLine), .txDataLine(txDataLine), .rxLine(rxLine), .rxEcho(rxEcho),
   .jabber(jabber), .symData(symData), .symErr(symErr), .symValid(symValid),
   .symReady(symReady), .overrun(overrun));

// ### sim/testbench.sv
// self-checking bench for jabber supervision and Manchester receive
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {int gap; logic sym; logic [1:0] exp;} mjirc_row_s;
   logic clk, rst, rxLine, go, stall, txEnIn, txDataIn, symReady;
   logic txEnLine, txDataLine, rxEcho, jabber, symData, symErr, symValid, overrun;
   logic sawOvr = 1'h0;
   logic [15:0] len;
   logic [1:0] e;
   logic [1:0] expQ[$];
   int miscompares = 0;
   int compares = 0;
   // gap before toggle, symbol expected, expected {data, err}
   mjirc_row_s rows[8] = '{'{500, 1'h1, 2'h2}, '{100, 1'h0, 2'h0}, '{80, 1'h1, 2'h2},
      '{220, 1'h1, 2'h0}, '{120, 1'h0, 2'h0}, '{100, 1'h1, 2'h0}, '{150, 1'h1, 2'h1},
      '{500, 1'h1, 2'h0}};
   mjirc_top #(.WINDOW_CYC(200), .HOLDOFF_CYC(1000), .TXIDLE_CYC(10)) dut_u (.clk(clk),
      .rst(rst), .txEnIn(txEnIn), .txDataIn(txDataIn), .txEnLine(txEnLine),
      .txDataLine(txDataLine), .rxLine(rxLine), .rxEcho(rxEcho), .jabber(jabber),
      .symData(symData), .symErr(symErr), .symValid(symValid), .symReady(symReady),
      .overrun(overrun));
   mjirc_mds_model mds_u (.clk(clk), .rst(rst), .go(go), .len(len), .stall(stall),
      .txEnIn(txEnIn), .txDataIn(txDataIn), .symReady(symReady));
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %b want %b", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic frame(input int n);
      len = 16'(n);
      go = 1'h1;
      cyc(1);
      go = 1'h0;
   endtask : frame
   task automatic waitJab(input logic v);
      int i;
      for (i = 0; i < 1200 && jabber !== v; i++) cyc(1);
      if (i == 1200) begin
         miscompares++;
         $display("ERROR %0t: jabber wait timed out", $time);
         report_and_stop();
      end
   endtask : waitJab
   // consumer side: symbol standing mid-cycle is the one the next edge pops
   always @(negedge clk) begin
      if (overrun === 1'h1) sawOvr <= 1'h1;
      if (!rst && symValid === 1'h1 && symReady === 1'h1) begin
         if (expQ.size() == 0) chk(1'h1, 1'h0);
         else begin
            e = expQ.pop_front();
            chk(symErr, e[0]);
            if (!e[0]) chk(symData, e[1]);
         end
      end
   end
   initial begin
      rst = 1'h1; rxLine = 1'h0; go = 1'h0; stall = 1'h0; len = 16'h0000;
      cyc(10);
      rst = 1'h0;
      chk(txEnLine | jabber | symValid | overrun, 1'h0);
      foreach (rows[i]) begin
         cyc(rows[i].gap);
         rxLine = ~rxLine;
         if (rows[i].sym) expQ.push_back(rows[i].exp);
      end
      cyc(10);
      chk(expQ.size() == 0, 1'h1);
      // stalled consumer: third symbol is dropped
      stall = 1'h1;
      for (int k = 0; k < 5; k++) begin
         cyc(k == 0 ? 500 : 100);
         rxLine = ~rxLine;
         if (k % 2 == 0 && k < 4) expQ.push_back(2'h2);
      end
      cyc(5);
      chk(sawOvr, 1'h1);
      chk(symValid, 1'h1);
      stall = 1'h0;
      cyc(5);
      chk(symValid, 1'h0);
      chk(expQ.size() == 0, 1'h1);
      frame(150);
      cyc(2);
      chk(txEnLine, 1'h1);
      cyc(200);
      chk(jabber, 1'h0);
      frame(300);
      waitJab(1'h1);
      chk(txEnLine, 1'h0);
      chk(rxEcho, 1'h0);
      expQ.push_back(2'h0);
      cyc(400);
      rxLine = 1'h0;
      cyc(3);
      chk(rxEcho, 1'h0);
      waitJab(1'h0);
      cyc(2);
      chk(txEnLine, 1'h0);
      frame(20);
      cyc(2);
      chk(txEnLine, 1'h1);
      cyc(40);
      frame(150);
      cyc(154);
      frame(150);
      cyc(45);
      chk(jabber, 1'h0);
      chk(txEnLine, 1'h1);
      cyc(1);
      chk(jabber, 1'h1);
      chk(txEnLine, 1'h0);
      rst = 1'h1;
      cyc(2);
      rst = 1'h0;
      chk(jabber | txEnLine, 1'h0);
      cyc(5);
      report_and_stop();
   end
endmodule : testbench
